// File: design/bbc_pkg.sv
// Package for the channel-two configuration register bank
package bbc_pkg;
	localparam logic [7:0] ADDR_TARGET_VOLTAGE = 8'h2d;
	localparam logic [7:0] ADDR_MODE_LIMIT_EN  = 8'h2e;
	// Contents after reset, before the factory load arrives
	localparam logic [7:0] RESET_VOLTAGE_CODE  = 8'h00;
	localparam logic [7:0] RESET_MODE_LIMIT_EN = 8'h04;
	// Field positions in the mode/limit/enable register
	localparam int TOPO_HI  = 7;
	localparam int TOPO_LO  = 6;
	localparam int LIMIT_HI = 5;
	localparam int LIMIT_LO = 4;
	localparam int DISCH_BIT = 3;
	localparam int EN_HI    = 2;
	localparam int EN_LO    = 0;
	// Voltage transfer: millivolts at code zero and per step
	localparam logic [12:0] VOUT_BASE_MV = 13'd500;
	localparam logic [12:0] VOUT_STEP_MV = 13'd25;
	// Peak current limits in milliamps
	localparam logic [9:0] ILIM_CODE0_MA = 10'd1000;
	localparam logic [9:0] ILIM_CODE1_MA = 10'd750;
	localparam logic [9:0] ILIM_CODE2_MA = 10'd500;
	localparam logic [9:0] ILIM_CODE3_MA = 10'd333;

	typedef enum logic [1:0] {
		BBC_TOPO_AUTO,
		BBC_TOPO_STEP_DOWN,
		BBC_TOPO_STEP_UP,
		BBC_TOPO_DOWN_UP
	} bbc_topo_t;

	// Register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bbc_req_t;

	// Decoded controls handed to the power stage
	typedef struct packed {
		bbc_topo_t   topology;
		logic [9:0]  ilim_ma;
		logic [12:0] vout_mv;
		logic        discharge_on;
		logic        channel_on;
		logic        use_sequencer;
		logic [1:0]  slot;
	} bbc_ctrl_t;
endpackage

// File: design/bbc_ch2_regs.sv
// Channel-two target voltage and mode/limit/enable registers with decode
// Function
// - Bits 7:6 select conversion topology
// - Bits 5:4: 01 is 0.750A, 10 is 0.500A
// - Code 00 is 1.000A, 11 is 0.333A
// - Discharge bit clear: no pull-down when off
// - Discharge bit set: pull-down when channel off
// - Enable codes 000-011 pick sequencer slot
// - Codes 10x force off, 11x force on
module bbc_ch2_regs (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic             clk_en,
	input  wire bbc_pkg::bbc_req_t req,
	input  wire logic [7:0]       otp_voltage_code,
	input  wire logic [7:0]       otp_mode_limit_enable,
	input  wire logic             otp_load,
	input  wire logic             seq_slot_on_0,
	input  wire logic             seq_slot_on_1,
	input  wire logic             seq_slot_on_2,
	input  wire logic             seq_slot_on_3,
	input  wire logic             bias_low_power_select,
	output logic [7:0]            rdata,
	output logic                  rvalid,
	output bbc_pkg::bbc_ctrl_t    ctrl
);
	// Stored register contents and their next values
	logic [7:0]         ch2_voltage_reg;
	logic [7:0]         ch2_mode_reg;
	logic [7:0]         ch2_voltage_next;
	logic [7:0]         ch2_mode_next;

	// Sequencer slot levels, two stages deep
	logic [3:0]         slot_sync1_reg;
	logic [3:0]         slot_sync2_reg;

	// Factory load strobe, two stages deep plus an edge memory
	logic               otp_sync1_reg;
	logic               otp_sync2_reg;
	logic               otp_seen_reg;

	// Factory values, staged as deep as their strobe
	logic [7:0]         otp_volt_sync1_reg;
	logic [7:0]         otp_volt_sync2_reg;
	logic [7:0]         otp_mode_sync1_reg;
	logic [7:0]         otp_mode_sync2_reg;

	// Next values of the registered outputs
	bbc_pkg::bbc_ctrl_t ctrl_next;
	logic [7:0]         rdata_next;
	logic               rvalid_next;

	// Millivolt value of a voltage code; code 255 still fits 13 bits
	function automatic logic [12:0] code_to_mv(input logic [7:0] code);
		code_to_mv = bbc_pkg::VOUT_BASE_MV + 13'(code) * bbc_pkg::VOUT_STEP_MV;
	endfunction

	// Milliamp value of a peak current limit code
	function automatic logic [9:0] code_to_ma(input logic [1:0] code);
		case (code)
			2'h0: code_to_ma = bbc_pkg::ILIM_CODE0_MA;
			2'h1: code_to_ma = bbc_pkg::ILIM_CODE1_MA;
			2'h2: code_to_ma = bbc_pkg::ILIM_CODE2_MA;
			default: code_to_ma = bbc_pkg::ILIM_CODE3_MA;
		endcase
	endfunction

	// Address decode of the register port
	wire        hit_volt  = req.addr == bbc_pkg::ADDR_TARGET_VOLTAGE;
	wire        hit_mode  = req.addr == bbc_pkg::ADDR_MODE_LIMIT_EN;
	wire        wr_volt   = req.wr & hit_volt;
	wire        wr_mode   = req.wr & hit_mode;

	// One-cycle pulse on the synchronised rise of the factory strobe
	wire        otp_rise  = otp_sync2_reg & ~otp_seen_reg;

	// Fields of the mode/limit/enable register
	wire [1:0]  topo_field = ch2_mode_reg[bbc_pkg::TOPO_HI:bbc_pkg::TOPO_LO];
	wire [2:0]  ch2_enable_control = ch2_mode_reg[bbc_pkg::EN_HI:bbc_pkg::EN_LO];
	wire [1:0]  ch2_peak_current_limit = ch2_mode_reg[bbc_pkg::LIMIT_HI:bbc_pkg::LIMIT_LO];
	wire        ch2_discharge_enable = ch2_mode_reg[bbc_pkg::DISCH_BIT];

	// Enable decode: top bit picks sequencer or forced state
	wire        sequenced = ~ch2_enable_control[2];
	wire        forced_on = ch2_enable_control[2] & ch2_enable_control[1];
	wire [1:0]  slot_sel  = ch2_enable_control[1:0];
	wire        slot_on   = slot_sync2_reg[slot_sel];

	// Bias low-power select is not an input to the enable path at all,
	// so flipping it while running cannot glitch the channel
	wire        chan_on   = sequenced ? slot_on : forced_on;

	// Pull-down only when allowed by the bit and the channel is off
	wire        pull_down = ch2_discharge_enable & ~chan_on;

	// Factory load beats a software write in the same cycle, so a
	// write landing on the load edge is lost rather than half applied
	assign ch2_voltage_next = otp_rise ? otp_volt_sync2_reg :
		(wr_volt ? req.wdata : ch2_voltage_reg);
	assign ch2_mode_next    = otp_rise ? otp_mode_sync2_reg :
		(wr_mode ? req.wdata : ch2_mode_reg);

	// Read selection; unmapped addresses read as zero
	assign rdata_next  = hit_volt ? ch2_voltage_reg :
		(hit_mode ? ch2_mode_reg : 8'h00);
	assign rvalid_next = req.rd;

	// Decode fields into power stage controls
	always_comb begin
		ctrl_next.topology      = bbc_pkg::bbc_topo_t'(topo_field);
		ctrl_next.ilim_ma       = code_to_ma(ch2_peak_current_limit);
		ctrl_next.vout_mv       = code_to_mv(ch2_voltage_reg);
		ctrl_next.channel_on    = chan_on;
		ctrl_next.discharge_on  = pull_down;
		ctrl_next.use_sequencer = sequenced;
		ctrl_next.slot          = slot_sel;
	end

	// Sequencer slot levels come from another domain
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			slot_sync1_reg <= 4'h0;
			slot_sync2_reg <= 4'h0;
		end else if (clk_en) begin
			slot_sync1_reg <= {seq_slot_on_3, seq_slot_on_2, seq_slot_on_1, seq_slot_on_0};
			slot_sync2_reg <= slot_sync1_reg;
		end
	end

	// Factory strobe: only the second stage feeds the edge detector
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			otp_sync1_reg <= 1'b0;
			otp_sync2_reg <= 1'b0;
			otp_seen_reg  <= 1'b0;
		end else if (clk_en) begin
			otp_sync1_reg <= otp_load;
			otp_sync2_reg <= otp_sync1_reg;
			otp_seen_reg  <= otp_sync2_reg;
		end
	end

	// Factory values staged with the strobe; they are quiet around a
	// load, so the copy taken on the load edge is settled
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			otp_volt_sync1_reg <= bbc_pkg::RESET_VOLTAGE_CODE;
			otp_volt_sync2_reg <= bbc_pkg::RESET_VOLTAGE_CODE;
			otp_mode_sync1_reg <= bbc_pkg::RESET_MODE_LIMIT_EN;
			otp_mode_sync2_reg <= bbc_pkg::RESET_MODE_LIMIT_EN;
		end else if (clk_en) begin
			otp_volt_sync1_reg <= otp_voltage_code;
			otp_volt_sync2_reg <= otp_volt_sync1_reg;
			otp_mode_sync1_reg <= otp_mode_limit_enable;
			otp_mode_sync2_reg <= otp_mode_sync1_reg;
		end
	end

	// Target voltage register
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ch2_voltage_reg <= bbc_pkg::RESET_VOLTAGE_CODE;
		end else if (clk_en) begin
			ch2_voltage_reg <= ch2_voltage_next;
		end
	end

	// Mode/limit/enable register; forced off until the factory load
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ch2_mode_reg <= bbc_pkg::RESET_MODE_LIMIT_EN;
		end else if (clk_en) begin
			ch2_mode_reg <= ch2_mode_next;
		end
	end

	// Read answer: pulse one cycle, data held until the next read
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdata  <= 8'h00;
			rvalid <= 1'b0;
		end else if (clk_en) begin
			rvalid <= rvalid_next;
			if (req.rd) begin
				rdata <= rdata_next;
			end
		end
	end

	// Power stage controls, registered so the stage never sees a
	// half-decoded field while a write lands
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= '0;
		end else if (clk_en) begin
			ctrl <= ctrl_next;
		end
	end

	// Limitations of this bank:
	// - the slot levels are taken as they come; sequencing order and
	//   timing belong to the sequencer, not to this bank
	// - a write to an unmapped address is dropped without any flag
	// - both registers load together from the factory values; a strobe
	//   that stays high loads once, a new load needs a low phase first
	// - the bias low-power select is accepted and left unused on purpose
	// - codes above the documented top voltage just continue linearly
endmodule

// File: verification/bbc_ch2_monitor.sv
// Port assertions for the channel-two register bank
module bbc_ch2_monitor (
	input wire logic               ref_clk,
	input wire logic               rstn,
	input wire logic               clk_en,
	input wire bbc_pkg::bbc_req_t  req,
	input wire logic               rvalid,
	input wire bbc_pkg::bbc_ctrl_t ctrl
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] p1, p2;
	wire [9:0] now = {req.wr & (req.addr == 8'h2d), req.wr & (req.addr == 8'h2e), req.wdata};
	wire [7:0] d = p2[7:0];
	wire v = p2[9];
	wire w = p2[8];
	// Write history two deep, frozen with clk_en as the bank is
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn) {p1, p2} <= '0;
		else if (clk_en) {p1, p2} <= {now, p1};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// Decode must follow each write two edges later
	property p_topo; w |-> ctrl.topology == d[7:6]; endproperty
	a_topo: assert property (p_topo) else $error("topology wrong");
	property p_ilim_mid; w && d[5] != d[4] |-> ctrl.ilim_ma == (d[4] ? 10'h2ee : 10'h1f4); endproperty
	a_ilim_mid: assert property (p_ilim_mid) else $error("limit wrong");
	property p_ilim_end; w && d[5] == d[4] |-> ctrl.ilim_ma == (d[4] ? 10'h14d : 10'h3e8); endproperty
	a_ilim_end: assert property (p_ilim_end) else $error("limit wrong");
	property p_dis_off; w && !d[3] |-> !ctrl.discharge_on; endproperty
	a_dis_off: assert property (p_dis_off) else $error("pull-down on");
	property p_dis_on; w && d[3] && d[2:1] == 2'h2 |-> ctrl.discharge_on; endproperty
	a_dis_on: assert property (p_dis_on) else $error("pull-down off");
	property p_slot; w && !d[2] |-> ctrl.use_sequencer && ctrl.slot == d[1:0]; endproperty
	a_slot: assert property (p_slot) else $error("slot wrong");
	property p_force; w && d[2] |-> !ctrl.use_sequencer && ctrl.channel_on == d[1]; endproperty
	a_force: assert property (p_force) else $error("forced state wrong");
	property p_vout; v |-> ctrl.vout_mv == 13'h1f4 + 13'h19 * d; endproperty
	a_vout: assert property (p_vout) else $error("voltage wrong");
	c_force: cover property (w && d[2]);
	c_seq: cover property (w && !d[2]);
	c_read: cover property (rvalid);
endmodule

// File: verification/bbc_ch2_regs_tb.sv
// Self-checking bench for the channel-two register bank
module bbc_ch2_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] d; logic [1:0] tp; logic [9:0] il; logic on, ds;} bbc_row_t;
	logic               ref_clk = 1'b0, rstn = 1'b0, bias = 1'b0, rvalid;
	logic [3:0]         son = 4'h0;
	logic               en = 1'b1, otp = 1'b0;
	logic [7:0]         ov = 8'h00, om = 8'h00;
	logic [7:0]         rdata;
	bbc_pkg::bbc_req_t  req = '0;
	bbc_pkg::bbc_ctrl_t ctrl;
	int                 n_mismatch = 0, n_checks = 0;
	bbc_row_t rows [5] = '{'{8'h06, 2'h0, 10'h3e8, 1'b1, 1'b0},
		'{8'h5c, 2'h1, 10'h2ee, 1'b0, 1'b1}, '{8'ha5, 2'h2, 10'h1f4, 1'b0, 1'b0},
		'{8'hf7, 2'h3, 10'h14d, 1'b1, 1'b0}, '{8'h0b, 2'h0, 10'h3e8, 1'b0, 1'b1}};
	bbc_ch2_regs bbc_ch2_regs_i (.ref_clk(ref_clk), .rstn(rstn), .clk_en(en), .req(req),
		.otp_voltage_code(ov), .otp_mode_limit_enable(om), .otp_load(otp),
		.seq_slot_on_0(son[0]), .seq_slot_on_1(son[1]), .seq_slot_on_2(son[2]),
		.seq_slot_on_3(son[3]), .bias_low_power_select(bias), .rdata(rdata), .rvalid(rvalid),
		.ctrl(ctrl));
	always #20 ref_clk = ~ref_clk;
	task chk(input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, s, e);
		end
	endtask
	// One access; a read checks its answer while the rvalid pulse stands,
	// a write waits out the two-edge decode
	task acc(input logic w, input logic [7:0] a, d);
		@(negedge ref_clk) req = '{w, !w, a, d};
		@(negedge ref_clk) begin
			if (!w) chk({rvalid, rdata}, {1'b1, d});
			req = '0;
		end
		@(negedge ref_clk);
		@(negedge ref_clk);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Watchdog, well past the roughly 140 cycles the run needs
	initial begin
		repeat (3000) @(posedge ref_clk);
		n_mismatch++;
		test_done;
	end
	initial begin
		repeat (2) @(negedge ref_clk);
		chk(ctrl, '0);
		rstn = 1'b1;
		@(negedge ref_clk) chk({ctrl.channel_on, ctrl.vout_mv}, {1'b0, 13'h1f4});
		foreach (rows[i]) begin
			acc(1'b1, 8'h2e, rows[i].d);
			chk({ctrl.topology, ctrl.ilim_ma, ctrl.channel_on, ctrl.discharge_on},
				{rows[i].tp, rows[i].il, rows[i].on, rows[i].ds});
			acc(1'b0, 8'h2e, rows[i].d);
		end
		// Each slot code must follow only its own sequencer input
		for (int k = 0; k < 4; k++) begin
			acc(1'b1, 8'h2e, 8'(k));
			son = 4'h1 << k;
			repeat (4) @(negedge ref_clk);
			chk({ctrl.use_sequencer, ctrl.slot, ctrl.channel_on}, {1'b1, 2'(k), 1'b1});
			son = ~son;
			repeat (4) @(negedge ref_clk);
			chk(ctrl.channel_on, 1'b0);
		end
		bias = 1'b0;
		acc(1'b1, 8'h2e, 8'h06);
		bias = 1'b1;
		repeat (4) @(negedge ref_clk);
		chk(ctrl.channel_on, 1'b1);
		acc(1'b1, 8'h2d, 8'hc7);
		chk(ctrl.vout_mv, 13'h1563);
		acc(1'b1, 8'h2f, 8'hff);
		acc(1'b0, 8'h2e, 8'h06);
		acc(1'b0, 8'h30, 8'h00);
		acc(1'b0, 8'h2d, 8'hc7);
		// Clock enable low: a write must not land
		en = 1'b0;
		acc(1'b1, 8'h2d, 8'h10);
		en = 1'b1;
		acc(1'b0, 8'h2d, 8'hc7);
		// Factory load replaces both registers
		ov = 8'h28;
		om = 8'h4e;
		otp = 1'b1;
		repeat (4) @(negedge ref_clk);
		chk({ctrl.topology, ctrl.ilim_ma, ctrl.channel_on, ctrl.vout_mv},
			{2'h1, 10'h3e8, 1'b1, 13'h5dc});
		otp = 1'b0;
		acc(1'b0, 8'h2e, 8'h4e);
		// Reset in mid-run returns to the reset values
		@(negedge ref_clk) rstn = 1'b0;
		@(negedge ref_clk) chk({rvalid, ctrl}, '0);
		rstn = 1'b1;
		@(negedge ref_clk) chk({ctrl.channel_on, ctrl.vout_mv}, {1'b0, 13'h1f4});
		acc(1'b0, 8'h2e, bbc_pkg::RESET_MODE_LIMIT_EN);
		test_done;
	end
endmodule
bind bbc_ch2_regs bbc_ch2_monitor bbc_ch2_monitor_i (.ref_clk(ref_clk), .rstn(rstn),
	.clk_en(clk_en), .req(req), .rvalid(rvalid), .ctrl(ctrl));
